// ==== hdl/fdc_pkg.sv ====
// Purpose: shared constants for the oscillator trim and clock request logic
// Assumes: 32-bit AXI4-Lite register bus, one 100 MHz clock
// Notes:   sleep mode codes are driven by the power manager
package fdc_pkg;

  // ==========================================================
  // oscillator field widths
  localparam int FDC_TAP_W = 5;
  localparam int FDC_FRAC_W = 5;
  localparam logic [FDC_FRAC_W-1:0] FDC_FRAC_TOP = 5'h1F;
  localparam logic [FDC_TAP_W-1:0] FDC_TAP_TOP = 5'h1F;
  // aclk cycles per oscillator tick at tap zero
  localparam logic [7:0] FDC_DCO_BASE = 8'h28;

  // ==========================================================
  // register byte offsets
  localparam logic [3:0] FDC_OFF_CTRL = 4'h0;
  localparam logic [3:0] FDC_OFF_TARGET = 4'h4;
  localparam logic [3:0] FDC_OFF_STATUS = 4'h8;
  localparam logic [3:0] FDC_OFF_TAP = 4'hC;

  // control register fields
  localparam int FDC_CTRL_GEN1_OFF = 0;
  localparam int FDC_CTRL_BYPASS = 1;
  localparam int FDC_CTRL_DCO_AUX = 2;
  localparam int FDC_CTRL_DCO_SUB = 3;
  // tap register fields
  localparam int FDC_TAP_LSB = 0;
  localparam int FDC_FRAC_LSB = 8;
  // status register fields
  localparam int FDC_ST_FLL_EN = 16;
  localparam int FDC_ST_STATE = 17;
  localparam int FDC_ST_LOWCUR = 19;

  // reset values
  localparam logic [15:0] FDC_TARGET_RST = 16'h0020;
  localparam logic [FDC_TAP_W-1:0] FDC_TAP_RST = 5'h10;
  localparam logic [FDC_FRAC_W-1:0] FDC_FRAC_RST = 5'h00;

  localparam logic [1:0] FDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] FDC_RESP_SLVERR = 2'h2;

  // ==========================================================
  // power modes reported by the power manager
  localparam logic [2:0] FDC_MODE_ACTIVE = 3'h0;
  localparam logic [2:0] FDC_MODE_LIGHT0 = 3'h1;
  localparam logic [2:0] FDC_MODE_LVL1 = 3'h2;
  localparam logic [2:0] FDC_MODE_LVL2 = 3'h3;
  localparam logic [2:0] FDC_MODE_DEEP3 = 3'h4;
  localparam logic [2:0] FDC_MODE_DEEP4 = 3'h5;

  // loop sequencer, gray along arm-measure-apply
  typedef enum logic [1:0] {
    FDC_LOOP_IDLE = 2'b00,
    FDC_LOOP_ARM = 2'b01,
    FDC_LOOP_MEAS = 2'b11,
    FDC_LOOP_APPLY = 2'b10
  } fdc_loop_e;

endpackage : fdc_pkg

// ==== hdl/fdc_modulator.sv ====
// Purpose: oscillator model mixing the selected tap with the next one up
// Assumes: tap and fraction are stable flops from the loop
// Notes:   one tick pulse per oscillator period, counted in aclk cycles
`timescale 1ns/10ps
module fdc_modulator
  import fdc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // trim fields
  input wire logic [FDC_TAP_W-1:0] osc_tap_sel,
  input wire logic [FDC_FRAC_W-1:0] tap_mix_fraction,
  // oscillator tick
  output logic dco_tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic [FDC_FRAC_W-1:0] acc;
    logic tick;
  } fdc_mod_s;

  fdc_mod_s s_q;
  fdc_mod_s s_d;
  logic [FDC_FRAC_W:0] sum;

  // ==========================================================
  // period generation
  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    sum = {1'b0, s_q.acc} + {1'b0, tap_mix_fraction};
    if (s_q.cnt == 8'h00)
    begin
      s_d.tick = 1'b1;
      s_d.acc = sum[FDC_FRAC_W-1:0];
      // mix next tap
      // the carry spreads fraction/32 of periods onto the faster tap
      if (sum[FDC_FRAC_W])
        s_d.cnt = FDC_DCO_BASE - 8'({3'h0, osc_tap_sel}) - 8'h02;
      else
        s_d.cnt = FDC_DCO_BASE - 8'({3'h0, osc_tap_sel}) - 8'h01;
    end
    else
    begin
      s_d.cnt = s_q.cnt - 8'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign dco_tick = s_q.tick;

endmodule : fdc_modulator

// ==== hdl/fdc_top.sv ====
// Purpose: frequency-locked loop, oscillator modulator, clock requests
// Assumes: ref_clk and power mode inputs are synchronous to aclk
// Notes:   registers over AXI4-Lite, one write and one read in flight
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module fdc_top
  import fdc_pkg::*;
#(
  parameter int NUM_SER = 2,
  parameter int CNT_W = 16
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reference clock and power state
  input wire logic ref_clk,
  input wire logic [2:0] power_mode,
  input wire logic isr_active,
  // serial units
  input wire logic [NUM_SER-1:0] ser_async_mode,
  input wire logic [NUM_SER-1:0] serial_soft_reset,
  input wire logic [NUM_SER-1:0] ser_busy,
  output logic [NUM_SER-1:0] ser_clk_req,
  // oscillator and crystal control
  output logic [FDC_TAP_W-1:0] osc_tap_sel,
  output logic [FDC_FRAC_W-1:0] tap_mix_fraction,
  output logic fll_active,
  output logic xtal1_digital_bypass,
  output logic low_current_ok
);

  // ==========================================================
  // parameter checks
  if (NUM_SER < 1 || NUM_SER > 8)
    $error("NUM_SER must be 1 to 8");
  if (CNT_W < 8 || CNT_W > 16)
    $error("CNT_W must be 8 to 16");

  // ==========================================================
  // state
  typedef struct packed {
    logic awready, wready;
    logic aw_have, w_have;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready, rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic gen1_off, bypass, dco_aux, dco_sub;
    logic [15:0] target;
    logic [FDC_TAP_W-1:0] tap;
    logic [FDC_FRAC_W-1:0] frac;
    fdc_loop_e loop;
    logic [CNT_W-1:0] cnt;
    logic ref_prev, fll_en;
    logic [1:0] dir;
    logic [NUM_SER-1:0] ser_req;
    logic low_cur;
  } fdc_top_s;

  fdc_top_s s_q;
  fdc_top_s s_d;
  logic dco_tick;
  logic ref_rise;
  logic [NUM_SER-1:0] ser_req_c;

  // ==========================================================
  // helpers
  function automatic logic deep_gate(input logic [2:0] mode);
    deep_gate = (mode == FDC_MODE_DEEP3) || (mode == FDC_MODE_DEEP4);
  endfunction : deep_gate

  function automatic logic [31:0] read_word(input logic [3:0] addr,
                                            input fdc_top_s s);
    read_word = 32'h0000_0000;
    case (addr)
      FDC_OFF_CTRL:
      begin
        read_word[FDC_CTRL_GEN1_OFF] = s.gen1_off;
        read_word[FDC_CTRL_BYPASS] = s.bypass;
        read_word[FDC_CTRL_DCO_AUX] = s.dco_aux;
        read_word[FDC_CTRL_DCO_SUB] = s.dco_sub;
      end
      FDC_OFF_TARGET: read_word[15:0] = s.target;
      FDC_OFF_STATUS:
      begin
        read_word[CNT_W-1:0] = s.cnt;
        read_word[FDC_ST_FLL_EN] = s.fll_en;
        read_word[FDC_ST_STATE +: 2] = s.loop;
        read_word[FDC_ST_LOWCUR] = s.low_cur;
      end
      FDC_OFF_TAP:
      begin
        read_word[FDC_TAP_LSB +: FDC_TAP_W] = s.tap;
        read_word[FDC_FRAC_LSB +: FDC_FRAC_W] = s.frac;
      end
      default: read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  function automatic logic mapped(input logic [3:0] addr);
    mapped = (addr[1:0] == 2'h0);
  endfunction : mapped

  // ==========================================================
  // oscillator
  fdc_modulator u_mod (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_tap_sel(s_q.tap),
    .tap_mix_fraction(s_q.frac),
    .dco_tick(dco_tick)
  );

  assign ref_rise = ref_clk && !s_q.ref_prev;

  // ==========================================================
  // serial clock requests
  // release idle async
  // sync units keep their clock since the far end clocks them
  for (genvar i = 0; i < NUM_SER; i++)
  begin : g_ser
    assign ser_req_c[i] = !serial_soft_reset[i] && (ser_busy[i] ||
                          !deep_gate(power_mode) || !ser_async_mode[i]);
  end

  // ==========================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.ref_prev = ref_clk;
    s_d.ser_req = ser_req_c;
    // write channel, address and data taken in either order
    if (s_q.awready && s_axi_awvalid)
    begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid)
    begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
    begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped(s_q.awaddr) ? FDC_RESP_OKAY : FDC_RESP_SLVERR;
      case (s_q.awaddr)
        FDC_OFF_CTRL:
          if (s_q.wstrb[0])
          begin
            s_d.gen1_off = s_q.wdata[FDC_CTRL_GEN1_OFF];
            s_d.bypass = s_q.wdata[FDC_CTRL_BYPASS];
            s_d.dco_aux = s_q.wdata[FDC_CTRL_DCO_AUX];
            s_d.dco_sub = s_q.wdata[FDC_CTRL_DCO_SUB];
          end
        FDC_OFF_TARGET:
        begin
          if (s_q.wstrb[0])
            s_d.target[7:0] = s_q.wdata[7:0];
          if (s_q.wstrb[1])
            s_d.target[15:8] = s_q.wdata[15:8];
        end
        FDC_OFF_TAP:
        begin
          if (s_q.wstrb[0])
            s_d.tap = s_q.wdata[FDC_TAP_LSB +: FDC_TAP_W];
          if (s_q.wstrb[1])
            s_d.frac = s_q.wdata[FDC_FRAC_LSB +: FDC_FRAC_W];
        end
        default: s_d.bresp = s_d.bresp;
      endcase
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;
    // read channel
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    if (s_q.arready && s_axi_arvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata = read_word(s_axi_araddr, s_q);
      s_d.rresp = mapped(s_axi_araddr) ? FDC_RESP_OKAY : FDC_RESP_SLVERR;
    end
    s_d.arready = !s_d.rvalid;
    // loop enable
    // an interrupt runs the cpu in active mode, so it wakes the loop too
    s_d.fll_en = 1'b1;
    if (!isr_active && power_mode != FDC_MODE_ACTIVE)
    begin
      if (power_mode == FDC_MODE_LIGHT0)
        s_d.fll_en = s_q.dco_aux || s_q.dco_sub;
      else
        s_d.fll_en = !s_q.gen1_off;
    end
    s_d.low_cur = !(power_mode == FDC_MODE_DEEP4 && s_q.bypass);

    // ==========================================================
    // loop sequencer
    if (!s_q.fll_en)
    begin
      // abort without trim
      // a half-done window is dropped so short wakes cannot drift the tap
      s_d.loop = FDC_LOOP_IDLE;
      s_d.cnt = '0;
    end
    else
    begin
      case (s_q.loop)
        FDC_LOOP_IDLE: s_d.loop = FDC_LOOP_ARM;
        // count is already clear here, idle is only reached with it zeroed
        FDC_LOOP_ARM:
          if (ref_rise)
            s_d.loop = FDC_LOOP_MEAS;
        FDC_LOOP_MEAS:
        begin
          if (dco_tick && s_q.cnt != '1)
            s_d.cnt = s_q.cnt + CNT_W'(1);
          if (ref_rise)
          begin
            s_d.loop = FDC_LOOP_APPLY;
            s_d.dir[0] = 32'(s_q.cnt) < 32'(s_q.target);
            s_d.dir[1] = 32'(s_q.cnt) > 32'(s_q.target);
          end
        end
        FDC_LOOP_APPLY:
        begin
          if (ref_rise)
          begin
            s_d.loop = FDC_LOOP_MEAS;
            s_d.cnt = '0;
            if (s_q.dir == 2'b01)
            begin
              // clean rollover
              // tap up pairs with fraction zero, never fraction 31
              if (s_q.frac != FDC_FRAC_TOP)
                s_d.frac = s_q.frac + FDC_FRAC_W'(1);
              else if (s_q.tap != FDC_TAP_TOP)
              begin
                s_d.frac = '0;
                s_d.tap = s_q.tap + FDC_TAP_W'(1);
              end
            end
            else if (s_q.dir == 2'b10)
            begin
              if (s_q.frac != '0)
                s_d.frac = s_q.frac - FDC_FRAC_W'(1);
              else if (s_q.tap != '0)
              begin
                s_d.frac = FDC_FRAC_TOP;
                s_d.tap = s_q.tap - FDC_TAP_W'(1);
              end
            end
          end
        end
        default: s_d.loop = FDC_LOOP_IDLE;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.target <= FDC_TARGET_RST;
      s_q.tap <= FDC_TAP_RST;
      s_q.frac <= FDC_FRAC_RST;
      s_q.loop <= FDC_LOOP_IDLE;
      s_q.low_cur <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign ser_clk_req = s_q.ser_req;
  assign osc_tap_sel = s_q.tap;
  assign tap_mix_fraction = s_q.frac;
  assign fll_active = s_q.fll_en;
  assign xtal1_digital_bypass = s_q.bypass;
  assign low_current_ok = s_q.low_cur;
endmodule : fdc_top

// ==== bench/fdc_top_properties.sv ====
// Purpose: port checks for oscillator trim, loop enable and clock requests
// Assumes: one aclk domain, aresetn synchronous active low
// Notes:   bound onto fdc_top from the bench top file
`timescale 1ns/10ps
module fdc_top_properties
  import fdc_pkg::*;
#(
  parameter int NUM_SER = 2,
  parameter int CNT_W = 16
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus and power state
  input wire logic s_axi_wvalid,
  input wire logic [2:0] power_mode,
  input wire logic isr_active,
  // serial units
  input wire logic [NUM_SER-1:0] ser_async_mode,
  input wire logic [NUM_SER-1:0] serial_soft_reset,
  input wire logic [NUM_SER-1:0] ser_busy,
  input wire logic [NUM_SER-1:0] ser_clk_req,
  // oscillator and crystal
  input wire logic [FDC_TAP_W-1:0] osc_tap_sel,
  input wire logic [FDC_FRAC_W-1:0] tap_mix_fraction,
  input wire logic fll_active,
  input wire logic xtal1_digital_bypass,
  input wire logic low_current_ok
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // crystal bypass
  property p_lowcur_block;
    (power_mode == FDC_MODE_DEEP4 && xtal1_digital_bypass) [*2]
      |-> !low_current_ok;
  endproperty
  a_lowcur_block: assert property (p_lowcur_block)
    else $error("low current granted while bypassed in deepest mode");
  property p_lowcur_clear;
    (!xtal1_digital_bypass) [*2] |-> low_current_ok;
  endproperty
  a_lowcur_clear: assert property (p_lowcur_clear)
    else $error("low current refused with bypass off");

  // ==========================================================
  // serial clock requests and loop enable
  property p_ser_release;
    $past((power_mode == FDC_MODE_DEEP3 || power_mode == FDC_MODE_DEEP4)
      && ser_async_mode[0] && !ser_busy[0]) |-> !ser_clk_req[0];
  endproperty
  a_ser_release: assert property (p_ser_release)
    else $error("idle async unit keeps its clock in deep sleep");
  property p_ser_off;
    serial_soft_reset[0] |=> !ser_clk_req[0];
  endproperty
  a_ser_off: assert property (p_ser_off)
    else $error("unit in soft reset requests a clock");
  property p_fll_on;
    (power_mode == FDC_MODE_ACTIVE || isr_active) |=> fll_active;
  endproperty
  a_fll_on: assert property (p_fll_on)
    else $error("loop not enabled in active mode or interrupt");

  // ==========================================================
  // trim movement, writes excluded
  property p_trim_hold;
    (!fll_active && !s_axi_wvalid) [*3]
      |-> $stable(osc_tap_sel) && $stable(tap_mix_fraction);
  endproperty
  a_trim_hold: assert property (p_trim_hold)
    else $error("trim moved while loop disabled");
  property p_trim_step;
    (!s_axi_wvalid) [*3] ##0
      ($changed(osc_tap_sel) || $changed(tap_mix_fraction))
    |-> ({1'b0, tap_mix_fraction} == {1'b0, $past(tap_mix_fraction)} + 6'h01
        && $stable(osc_tap_sel))
     || ({1'b0, $past(tap_mix_fraction)} == {1'b0, tap_mix_fraction} + 6'h01
        && $stable(osc_tap_sel))
     || ($past(tap_mix_fraction) == FDC_FRAC_TOP && tap_mix_fraction == '0
        && osc_tap_sel == $past(osc_tap_sel) + 5'h01)
     || ($past(tap_mix_fraction) == '0 && tap_mix_fraction == FDC_FRAC_TOP
        && osc_tap_sel == $past(osc_tap_sel) - 5'h01);
  endproperty
  a_trim_step: assert property (p_trim_step)
    else $error("trim moved by more than one fraction step");
  property p_no_jump;
    (!s_axi_wvalid) [*3] ##0 ($past(tap_mix_fraction) == FDC_FRAC_TOP
      && osc_tap_sel != $past(osc_tap_sel)) |-> tap_mix_fraction == '0;
  endproperty
  a_no_jump: assert property (p_no_jump)
    else $error("tap stepped without fraction rollover");

  c_roll: cover property ($past(tap_mix_fraction) == FDC_FRAC_TOP
    && tap_mix_fraction == '0);
  c_ser_drop: cover property ($fell(ser_clk_req[0]));
  c_lowcur: cover property (!low_current_ok);
endmodule : fdc_top_properties

// ==== bench/fdc_far_model.sv ====
// Purpose: reference crystal and clock-consuming serial units
// Assumes: driven off aclk rising edges
// Notes:   reference stands still low while disabled
`timescale 1ns/10ps
module fdc_far_model
#(
  parameter int NUM_SER = 2,
  parameter int REF_HALF = 100,
  parameter int XFER = 60
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // reference crystal
  input wire logic ref_en,
  output logic ref_clk,
  // serial units
  input wire logic [NUM_SER-1:0] xfer_start,
  input wire logic [NUM_SER-1:0] ser_clk_req,
  output logic [NUM_SER-1:0] ser_busy,
  output logic clk_lost
);
  int ref_cnt = 0;
  int xf [NUM_SER];
  logic [NUM_SER-1:0] busy_q = '0;

  initial
  begin
    ref_clk = 1'b0;
    clk_lost = 1'b0;
    foreach (xf[i]) xf[i] = 0;
  end

  always_comb
    foreach (xf[i]) ser_busy[i] = (xf[i] != 0);

  always @(posedge aclk)
  begin
    ref_cnt <= (!ref_en || ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
    if (!ref_en)
      ref_clk <= 1'b0;
    else if (ref_cnt == REF_HALF - 1)
      ref_clk <= !ref_clk;
    foreach (xf[i]) xf[i] <= xfer_start[i] ? XFER : (xf[i] > 0 ? xf[i] - 1 : 0);
    busy_q <= ser_busy;
    // a unit mid-transfer must never lose its clock
    if (!aresetn)
      clk_lost <= 1'b0;
    else if (|(busy_q & ser_busy & ~ser_clk_req))
      clk_lost <= 1'b1;
  end
endmodule : fdc_far_model

// ==== bench/test_fll_dco_clock_system.sv ====
// Purpose: register and port level tests of the trim loop block
// Assumes: reference period of 200 aclk cycles from the far model
// Notes:   trim tests change targets only while the loop is off
`timescale 1ns/10ps
module test_fll_dco_clock_system;
  import fdc_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr, araddr, strb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, resp;
  logic ref_clk, ref_en, isr, fll, byp, lco, lost;
  logic [2:0] mode;
  logic [1:0] s_async, s_srst, s_busy, s_req, start;
  logic [4:0] tap, frac;
  int err_total, n_tests;
  // mode, ctrl, interrupt, expected loop enable
  logic [8:0] lp [10] = '{{FDC_MODE_ACTIVE, 4'h1, 2'b01},
    {FDC_MODE_LIGHT0, 4'h0, 2'b00}, {FDC_MODE_LIGHT0, 4'h4, 2'b01},
    {FDC_MODE_LIGHT0, 4'h8, 2'b01}, {FDC_MODE_LVL1, 4'h1, 2'b00},
    {FDC_MODE_LVL2, 4'h0, 2'b01}, {FDC_MODE_DEEP3, 4'h1, 2'b00},
    {FDC_MODE_DEEP3, 4'h0, 2'b01}, {FDC_MODE_DEEP4, 4'h1, 2'b00},
    {FDC_MODE_DEEP4, 4'h1, 2'b11}};
  logic [2:0] sm [4] = '{FDC_MODE_DEEP3, FDC_MODE_DEEP4, FDC_MODE_ACTIVE,
    FDC_MODE_LIGHT0};

  fdc_top #(.NUM_SER(2), .CNT_W(16)) u_fdc_top (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ref_clk(ref_clk), .power_mode(mode), .isr_active(isr),
    .ser_async_mode(s_async), .serial_soft_reset(s_srst),
    .ser_busy(s_busy), .ser_clk_req(s_req), .osc_tap_sel(tap),
    .tap_mix_fraction(frac), .fll_active(fll),
    .xtal1_digital_bypass(byp), .low_current_ok(lco));

  fdc_far_model #(.NUM_SER(2), .REF_HALF(100), .XFER(60)) u_fdc_far_model (
    .aclk(aclk), .aresetn(aresetn), .ref_en(ref_en), .ref_clk(ref_clk),
    .xfer_start(start), .ser_clk_req(s_req), .ser_busy(s_busy),
    .clk_lost(lost));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ==========================================================
  // bus tasks and compares
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
  endtask : wr

  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    resp = rresp;
    chk(rdata, exp);
  endtask : rchk

  // waits for the next loop correction, bounded
  task automatic wait_trim(input logic [4:0] et, input logic [4:0] ef);
    logic [9:0] old;
    int n;
    old = {tap, frac};
    n = 0;
    while ({tap, frac} === old && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    chk({22'h0, tap, frac}, {22'h0, et, ef});
  endtask : wait_trim

  task automatic results;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  initial
  begin
    #200000;
    err_total++;
    results();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, arvalid} = '0;
    // response ready stays high: every answer is taken at once
    {bready, rready, strb} = 6'h3F;
    {awaddr, araddr, wdata, ref_en, isr, start, s_srst} = '0;
    mode = FDC_MODE_LVL1;
    s_async = 2'b11;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(FDC_OFF_TAP, 32'(FDC_TAP_RST));
    rchk(FDC_OFF_TARGET, 32'(FDC_TARGET_RST));
    rchk(4'h2, 32'h0);
    chk(32'(resp), 32'(FDC_RESP_SLVERR));
    foreach (lp[i])
    begin
      wr(FDC_OFF_CTRL, 32'(lp[i][5:2]));
      mode <= lp[i][8:6];
      isr <= lp[i][1];
      cyc(3);
      chk(32'(fll), 32'(lp[i][0]));
    end
    isr <= 1'b0;
    wr(FDC_OFF_CTRL, 32'h2);
    chk(32'(resp), 32'(FDC_RESP_OKAY));
    cyc(3);
    chk({30'h0, byp, lco}, 32'h2);
    wr(FDC_OFF_CTRL, 32'h0);
    cyc(3);
    chk({30'h0, byp, lco}, 32'h1);
    start <= 2'b10;
    @(posedge aclk);
    start <= 2'b00;
    foreach (sm[i])
    begin
      mode <= sm[i];
      cyc(3);
      chk(32'(s_req), (sm[i] == FDC_MODE_DEEP3 || sm[i] == FDC_MODE_DEEP4)
        ? 32'h2 : 32'h3);
    end
    // let the transfer finish so soft reset never cuts a busy unit's clock
    cyc(50);
    s_srst <= 2'b11;
    cyc(3);
    chk(32'(s_req), 32'h0);
    s_srst <= 2'b00;
    s_async <= 2'b10;
    mode <= FDC_MODE_DEEP3;
    cyc(3);
    chk(32'(s_req), 32'h1);
    s_async <= 2'b11;
    wr(FDC_OFF_CTRL, 32'h1);
    ref_en <= 1'b1;
    wr(FDC_OFF_TAP, 32'h1F05);
    cyc(400);
    mode <= FDC_MODE_ACTIVE;
    cyc(150);
    mode <= FDC_MODE_DEEP3;
    cyc(400);
    rchk(FDC_OFF_TAP, 32'h1F05);
    rchk(FDC_OFF_STATUS, 32'h1 << FDC_ST_LOWCUR);
    strb <= 4'h1;
    wr(FDC_OFF_TAP, 32'h0005);
    strb <= 4'hF;
    rchk(FDC_OFF_TAP, 32'h1F05);
    mode <= FDC_MODE_ACTIVE;
    wait_trim(5'h06, 5'h00);
    wait_trim(5'h06, 5'h01);
    mode <= FDC_MODE_DEEP3;
    cyc(3);
    wr(FDC_OFF_TARGET, 32'h0);
    wr(FDC_OFF_TAP, 32'h0006);
    mode <= FDC_MODE_ACTIVE;
    wait_trim(5'h05, 5'h1F);
    rchk(FDC_OFF_TAP, 32'h1F05);
    chk(32'(lost), 32'h0);
    results();
  end
endmodule : test_fll_dco_clock_system

bind fdc_top fdc_top_properties #(.NUM_SER(NUM_SER), .CNT_W(CNT_W))
  u_fdc_top_properties (.aclk(aclk), .aresetn(aresetn),
  .s_axi_wvalid(s_axi_wvalid), .power_mode(power_mode),
  .isr_active(isr_active), .ser_async_mode(ser_async_mode),
  .serial_soft_reset(serial_soft_reset), .ser_busy(ser_busy),
  .ser_clk_req(ser_clk_req), .osc_tap_sel(osc_tap_sel),
  .tap_mix_fraction(tap_mix_fraction), .fll_active(fll_active),
  .xtal1_digital_bypass(xtal1_digital_bypass),
  .low_current_ok(low_current_ok));
